/* File: eec_ctrl.sv */
// Purpose: command sequencing, error checking and execution for the array
// Assumes: mode inputs come from logic on hclk; one wait state per transfer
// Notes: array contents are not reset and hold no defined value at power-up
`timescale 1ns/1ps
`default_nettype none
module eec_ctrl
    import eec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire eec_mode_t mode,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic hv_on
);

    function automatic logic cmd_valid(input logic [7:0] c);
        return c == CMD_VERIFY || c == CMD_PROGRAM || c == CMD_SECT_ERASE ||
               c == CMD_MASS_ERASE || c == CMD_SECT_MODIFY;
    endfunction

    function automatic logic cmd_targets_word(input logic [7:0] c);
        return c == CMD_PROGRAM || c == CMD_SECT_ERASE || c == CMD_SECT_MODIFY;
    endfunction

    function automatic logic cmd_walks(input logic [7:0] c);
        return c == CMD_VERIFY || c == CMD_MASS_ERASE;
    endfunction

    function automatic logic [3:0] ticks_of(input logic [7:0] c);
        if (c == CMD_VERIFY || !cmd_valid(c))
            return TICKS_SHORT;
        else if (c == CMD_SECT_MODIFY || c == CMD_MASS_ERASE)
            return TICKS_LONG;
        else
            return TICKS_WORD;
    endfunction

    logic acc_pend;
    logic [31:0] acc_addr;
    logic acc_write;
    logic [2:0] acc_size;
    logic [7:0] clkdiv;
    logic [7:0] config_reg;
    logic [7:0] prot;
    logic prot_locked;
    logic be, cc, pv, ae, blank;
    eec_seq_t seq;
    eec_cmd_t buf_cmd;
    eec_cmd_t pend_cmd;
    logic pend_valid;
    eec_exec_t ex_state;
    eec_cmd_t act;
    logic [3:0] ticks_left;
    logic [6:0] prescale;
    logic [IDX_W-1:0] walk;
    logic all_blank;
    logic stop_q;
    logic [15:0] mem [ARR_WORDS];

    logic wr, reg_hit, arr_hit, arr_bad;
    logic wr_arr, wr_div, wr_cfg, wr_prot, wr_stat, wr_cmd, wr_reg_any;
    logic prot_on, area_prot, cmd_ok;
    logic ae_hit, pv_hit, launch, take, tick, finish, stop_entry, stop_exit, stop_abort;
    logic [IDX_W:0] prot_words;
    logic [IDX_W-1:0] idx_even, idx_odd;

    // bus slave: one wait state, access done in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_pend <= 1'b0;
            acc_addr <= 32'h0000_0000;
            acc_write <= 1'b0;
            acc_size <= 3'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (acc_pend) begin
                acc_pend <= 1'b0;
                hreadyout <= 1'b1;
            end else if (hsel && htrans[1] && hready) begin
                acc_pend <= 1'b1;
                hreadyout <= 1'b0;
                acc_addr <= haddr;
                acc_write <= hwrite;
                acc_size <= hsize;
            end
        end
    end

    always_comb begin
        wr = acc_pend && acc_write;
        reg_hit = acc_addr[31:12] == REG_PAGE;
        arr_hit = acc_addr[31:12] == ARR_PAGE;
        arr_bad = acc_size != HSIZE_WORD || acc_addr[1:0] != 2'h0;
        wr_arr = wr && arr_hit;
        wr_div = wr && reg_hit && acc_addr[11:0] == OFS_CLKDIV;
        wr_cfg = wr && reg_hit && acc_addr[11:0] == OFS_CONFIG;
        wr_prot = wr && reg_hit && acc_addr[11:0] == OFS_PROT;
        wr_stat = wr && reg_hit && acc_addr[11:0] == OFS_STATUS;
        wr_cmd = wr && reg_hit && acc_addr[11:0] == OFS_CMD;
        wr_reg_any = wr_div || wr_cfg || wr_prot || wr_stat || wr_cmd;
        stop_entry = mode.stop_req && !stop_q;
        stop_exit = !mode.stop_req && stop_q;
        // abort only if a command is active
        stop_abort = stop_entry && !cc;
        prot_on = !prot[PROT_OPEN];
        prot_words = PROT_UNIT << prot[2:0];
        area_prot = prot_on && ({1'b0, buf_cmd.idx} >= (11'h400 - prot_words));
        if (mode.secured && mode.special)
            cmd_ok = hwdata[7:0] == CMD_MASS_ERASE;
        // code check skipped in unsecured special mode
        else if (mode.special)
            cmd_ok = 1'b1;
        else
            cmd_ok = cmd_valid(hwdata[7:0]);
        ae_hit = 1'b0;
        if (wr_arr && (!clkdiv[DIV_LOADED] || arr_bad || !be || seq != SQ_IDLE))
            ae_hit = 1'b1;
        // only command may follow the word
        if (seq == SQ_WORD && wr_reg_any && !wr_cmd)
            ae_hit = 1'b1;
        if (wr_cmd && seq != SQ_WORD)
            ae_hit = 1'b1;
        if (wr_cmd && seq == SQ_WORD && !cmd_ok)
            ae_hit = 1'b1;
        // only status may follow the command
        if (seq == SQ_CMD && wr_reg_any && !wr_stat)
            ae_hit = 1'b1;
        if (wr_stat && !hwdata[ST_BE])
            ae_hit = 1'b1;
        pv_hit = 1'b0;
        if (wr_cmd && seq == SQ_WORD && cmd_ok) begin
            if (cmd_targets_word(hwdata[7:0]) && area_prot)
                pv_hit = 1'b1;
            if (hwdata[7:0] == CMD_MASS_ERASE && prot_on)
                pv_hit = 1'b1;
        end
        launch = wr_stat && hwdata[ST_BE] && seq == SQ_CMD && !ae && !pv && !mode.stop_req;
        take = pend_valid && ex_state == EX_IDLE && !mode.stop_req;
        tick = prescale == clkdiv[6:0];
        finish = !stop_entry && ((ex_state == EX_WAIT && tick && ticks_left == 4'h1 && !cmd_walks(act.code)) ||
                 (ex_state == EX_WALK && walk == IDX_LAST));
        idx_even = {act.idx[IDX_W-1:1], 1'b0};
        idx_odd = {act.idx[IDX_W-1:1], 1'b1};
    end

    // register file: divider, configuration, protection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clkdiv <= CLKDIV_RESET;
            config_reg <= CONFIG_RESET;
            prot <= PROT_RESET;
            prot_locked <= 1'b0;
        end else begin
            if (wr_div)
                clkdiv <= {1'b1, hwdata[6:0]};
            if (wr_cfg)
                config_reg <= {hwdata[CFG_BEIE], hwdata[CFG_COMPLETE_IRQ_ENABLE], 6'h00};
            if (wr_prot && (mode.debug || !prot_locked)) begin
                prot <= hwdata[7:0];
                prot_locked <= 1'b1;
            end
        end
    end

    // read data; register reads have no side effects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc_pend && !acc_write) begin
            hrdata <= 32'h0000_0000;
            if (arr_hit)
                hrdata <= cc ? {16'h0000, mem[acc_addr[IDX_W+1:2]]} : INVALID_READ;
            // reads do not touch the sequence
            else if (reg_hit) begin
                case (acc_addr[11:0])
                    OFS_CLKDIV: hrdata <= {24'h000000, clkdiv};
                    OFS_CONFIG: hrdata <= {24'h000000, config_reg};
                    OFS_PROT: hrdata <= {24'h000000, prot};
                    OFS_STATUS: hrdata <= {24'h000000, be, cc, pv, ae, 1'b0, blank, 2'h0};
                    OFS_CMD: hrdata <= {24'h000000, buf_cmd.code};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // command write sequence and buffer stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq <= SQ_IDLE;
            buf_cmd <= '0;
            stop_q <= 1'b0;
        end else begin
            stop_q <= mode.stop_req;
            if (ae_hit || pv_hit || stop_entry || stop_exit) begin
                seq <= SQ_IDLE;
            end else if (wr_arr) begin
                seq <= SQ_WORD;
                buf_cmd.idx <= acc_addr[IDX_W+1:2];
                buf_cmd.data <= hwdata[15:0];
            end else if (wr_cmd) begin
                seq <= SQ_CMD;
                buf_cmd.code <= hwdata[7:0];
            end else if (launch) begin
                seq <= SQ_IDLE;
            end
        end
    end

    // pending slot of the two-stage pipeline
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_valid <= 1'b0;
            pend_cmd <= '0;
        end else if (stop_entry || stop_exit) begin
            pend_valid <= 1'b0;
        end else if (launch) begin
            pend_valid <= 1'b1;
            pend_cmd <= buf_cmd;
        end else if (take) begin
            pend_valid <= 1'b0;
        end
    end

    // status flags; a hardware set beats a software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            be <= 1'b1;
            cc <= 1'b1;
            ae <= 1'b0;
            pv <= 1'b0;
            blank <= 1'b0;
        end else begin
            if (ae_hit || stop_abort)
                ae <= 1'b1;
            else if (wr_stat && hwdata[ST_AE])
                ae <= 1'b0;
            if (pv_hit)
                pv <= 1'b1;
            else if (wr_stat && hwdata[ST_PV])
                pv <= 1'b0;
            if (launch)
                be <= 1'b0;
            else if (take || stop_exit)
                be <= 1'b1;
            if (launch)
                cc <= 1'b0;
            else if (stop_abort || (finish && !pend_valid))
                cc <= 1'b1;
            if (take && pend_cmd.code == CMD_VERIFY)
                blank <= 1'b0;
            else if (finish && act.code == CMD_VERIFY)
                blank <= all_blank && mem[walk] == ERASED_WORD;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ex_state <= EX_IDLE;
            act <= '0;
            ticks_left <= 4'h0;
            prescale <= 7'h00;
            walk <= '0;
            all_blank <= 1'b0;
            hv_on <= 1'b0;
        end else begin
            prescale <= (tick || ex_state != EX_WAIT) ? 7'h00 : prescale + 7'h01;
            case (ex_state)
                EX_IDLE: begin
                    if (take) begin
                        act <= pend_cmd;
                        ticks_left <= ticks_of(pend_cmd.code);
                        ex_state <= EX_WAIT;
                        hv_on <= cmd_valid(pend_cmd.code) && pend_cmd.code != CMD_VERIFY;
                    end
                end
                EX_WAIT: begin
                    if (stop_entry) begin
                        ex_state <= EX_IDLE;
                        hv_on <= 1'b0;
                    end else if (tick) begin
                        ticks_left <= ticks_left - 4'h1;
                        if (ticks_left == 4'h1) begin
                            ex_state <= cmd_walks(act.code) ? EX_WALK : EX_IDLE;
                            hv_on <= act.code == CMD_MASS_ERASE;
                            walk <= '0;
                            all_blank <= 1'b1;
                        end
                    end
                end
                EX_WALK: begin
                    walk <= walk + 10'h001;
                    if (mem[walk] != ERASED_WORD)
                        all_blank <= 1'b0;
                    if (stop_entry || walk == IDX_LAST) begin
                        ex_state <= EX_IDLE;
                        hv_on <= 1'b0;
                    end
                end
                default: ex_state <= EX_IDLE;
            endcase
        end
    end

    // array update at the end of program and sector operations, per word during the mass erase walk
    always_ff @(posedge hclk) begin
        if (finish && act.code == CMD_PROGRAM)
            mem[act.idx] <= act.data;
        if (finish && (act.code == CMD_SECT_ERASE || act.code == CMD_SECT_MODIFY)) begin
            mem[idx_even] <= ERASED_WORD;
            mem[idx_odd] <= ERASED_WORD;
            if (act.code == CMD_SECT_MODIFY)
                mem[act.idx] <= act.data;
        end
        if (ex_state == EX_WALK && !stop_entry && act.code == CMD_MASS_ERASE)
            mem[walk] <= ERASED_WORD;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= !mode.irq_mask && ((be && config_reg[CFG_BEIE]) || (cc && config_reg[CFG_COMPLETE_IRQ_ENABLE]));
    end

endmodule // eec_ctrl
`default_nettype wire

/* File: eec_pkg.sv */
// Purpose: constants and types for the nonvolatile array command controller
// Assumes: 32-bit AHB-Lite register bus, 40 MHz hclk
package eec_pkg;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    localparam logic [11:0] OFS_CLKDIV = 12'h000;
    localparam logic [11:0] OFS_CONFIG = 12'h004;
    localparam logic [11:0] OFS_PROT = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_CMD = 12'h010;
    localparam logic [19:0] REG_PAGE = 20'h00000;
    localparam logic [19:0] ARR_PAGE = 20'h00001;

    localparam int IDX_W = 10;
    localparam int ARR_WORDS = 1024;
    localparam logic [IDX_W-1:0] IDX_LAST = 10'h3FF;

    // field positions
    localparam int DIV_LOADED = 7;
    localparam int CFG_BEIE = 7;
    localparam int CFG_COMPLETE_IRQ_ENABLE = 6;
    localparam int PROT_OPEN = 7;
    localparam int ST_BE = 7;
    localparam int ST_CC = 6;
    localparam int ST_PV = 5;
    localparam int ST_AE = 4;
    localparam int ST_BLANK = 2;

    localparam logic [7:0] CLKDIV_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'h80;
    localparam logic [IDX_W:0] PROT_UNIT = 11'h010;

    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    localparam logic [7:0] CMD_SECT_MODIFY = 8'h60;

    // execution length in divided timebase ticks
    localparam logic [3:0] TICKS_SHORT = 4'h2;
    localparam logic [3:0] TICKS_WORD = 4'h4;
    localparam logic [3:0] TICKS_LONG = 4'h8;

    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [31:0] INVALID_READ = 32'hBAD0_BAD0;

    typedef struct packed {
        logic wait_req;
        logic stop_req;
        logic debug;
        logic secured;
        logic special;
        logic irq_mask;
    } eec_mode_t;

    typedef struct packed {
        logic [7:0] code;
        logic [IDX_W-1:0] idx;
        logic [15:0] data;
    } eec_cmd_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_WORD = 2'b01,
        SQ_CMD = 2'b10
    } eec_seq_t;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_WAIT = 2'b01,
        EX_WALK = 2'b10
    } eec_exec_t;

endpackage

/* File: eec_ctrl_properties.sv */
// Purpose: port-level checks of the array command controller
// Assumes: one slave, hready tied to hreadyout
// Notes: helper logic shadows bus writes to config, divider and status
`timescale 1ns/1ps
`default_nettype none
module eec_ctrl_properties
    import eec_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire eec_mode_t mode,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq,
    input wire logic hv_on
);
    logic a_v;
    logic a_wr;
    logic [31:0] a_ad;
    logic dv_q;
    logic [1:0] cfg_q;
    logic [3:0] lhist;
    logic wdone;
    assign wdone = a_v && a_wr && !hreadyout;
    // address phase shadow
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_v <= 1'b0;
            a_wr <= 1'b0;
            a_ad <= 32'h0;
        end else begin
            a_v <= hsel && htrans[1] && hready;
            if (hready) begin
                a_wr <= hwrite;
                a_ad <= haddr;
            end
        end
    end
    // register shadows from write data phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_q <= 1'b0;
            cfg_q <= 2'h0;
            lhist <= 4'h0;
        end else begin
            if (wdone && a_ad == {REG_PAGE, OFS_CLKDIV}) dv_q <= 1'b1;
            if (wdone && a_ad == {REG_PAGE, OFS_CONFIG}) cfg_q <= hwdata[CFG_BEIE:CFG_COMPLETE_IRQ_ENABLE];
            lhist <= {lhist[2:0], wdone && a_ad == {REG_PAGE, OFS_STATUS} && hwdata[ST_BE]};
        end
    end
    AST_HRESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn) hresp == 1'b0)
        else $error("hresp not OKAY");
    AST_ONE_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout) else $error("wait state count wrong");
    AST_HRDATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved outside data phase");
    AST_IRQ_MASK: assert property (@(posedge hclk) disable iff (!hresetn) mode.irq_mask |=> !irq)
        else $error("irq high while masked");
    AST_IRQ_ENABLES: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_q == 2'h0 && $past(cfg_q) == 2'h0 |-> !irq) else $error("irq high with enables off");
    AST_STOP_HV: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(mode.stop_req) |-> ##[1:2] !hv_on) else $error("high voltage kept in stop");
    AST_HV_NEEDS_DIV: assert property (@(posedge hclk) disable iff (!hresetn) !dv_q |-> !hv_on)
        else $error("execution without divider");
    AST_HV_LAUNCH: assert property (@(posedge hclk) disable iff (!hresetn) $rose(hv_on) |-> lhist != 4'h0)
        else $error("execution without launch");
endmodule // eec_ctrl_properties
bind eec_ctrl eec_ctrl_properties i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .mode(mode),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .hv_on(hv_on));
`default_nettype wire

/* File: eec_cpu.sv */
// Purpose: processor model issuing single bus transfers of the size given by the caller
// Assumes: called just after a rising edge
// Notes: released address and data carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module eec_cpu
    import eec_pkg::*;
(
    input wire logic hclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hready_q() !== 1'b1);
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= d;
        do @(posedge hclk); while (hready_q() !== 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask
    function automatic logic hready_q();
        return hreadyout;
    endfunction
endmodule // eec_cpu
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the array command controller
// Assumes: divider kept small so execution stays short
// Notes: random data and index from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench
    import eec_pkg::*;
;
    localparam logic [31:0] A_DIV = {REG_PAGE, OFS_CLKDIV};
    localparam logic [31:0] A_CFG = {REG_PAGE, OFS_CONFIG};
    localparam logic [31:0] A_PROT = {REG_PAGE, OFS_PROT};
    localparam logic [31:0] A_ST = {REG_PAGE, OFS_STATUS};
    localparam logic [31:0] A_CMD = {REG_PAGE, OFS_CMD};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq, hv_on;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    eec_mode_t mode = '0;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [7:0] ops [5] = '{CMD_MASS_ERASE, CMD_VERIFY, CMD_PROGRAM, CMD_SECT_ERASE, CMD_SECT_MODIFY};
    logic [9:0] idx;
    logic [15:0] d;
    logic [7:0] dv;
    always #12.5 hclk = ~hclk;
    eec_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .mode(mode), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .hv_on(hv_on));
    eec_cpu i_cpu (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    function automatic logic [31:0] arr(input logic [9:0] i);
        return {ARR_PAGE, i, 2'b00};
    endfunction
    function automatic logic [15:0] after_op(input logic [7:0] c, input logic [15:0] v);
        return (c == CMD_PROGRAM || c == CMD_SECT_MODIFY) ? v : ERASED_WORD;
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [31:0] x;
        i_cpu.xfer(a, 1'b1, HSIZE_WORD, v, x);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] x);
        i_cpu.xfer(a, 1'b0, HSIZE_WORD, 32'h0, x);
    endtask
    task automatic cst(input logic [7:0] e, input logic [7:0] m);
        logic [31:0] x;
        rd(A_ST, x);
        chk(x, {24'h0, e}, {24'h0, m});
    endtask
    task automatic seq(input logic [9:0] i, input logic [15:0] v, input logic [7:0] c);
        wr(arr(i), {16'h0, v});
        wr(A_CMD, {24'h0, c});
        wr(A_ST, 32'h80);
    endtask
    task automatic wdone();
        logic [31:0] x;
        for (int n = 0; n < 800; n++) begin
            rd(A_ST, x);
            if (x[ST_CC] === 1'b1) break;
        end
    endtask
    // locked attempt must not launch, then abort and clear both flags
    task automatic lock_chk(input logic [7:0] e, input logic [7:0] m);
        seq(10'h0, 16'h0, CMD_SECT_ERASE);
        cst(e, m);
        wr(A_ST, 32'h10);
        wr(A_ST, 32'hB0);
        cst(8'hC0, 8'hF0);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            $display("BAD %0t timeout", $time);
            close_out();
        end
    end
    initial begin
        void'($urandom(7));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cst(8'hC0, 8'hF0);
        rd(A_PROT, r);
        chk(r, {24'h0, PROT_RESET}, 32'hFF);
        rd(32'h0000_0020, r);
        chk(r, 32'h0, 32'hFFFF_FFFF);
        wr(arr(10'h0), 32'h0);
        cst(8'h10, 8'h10);
        wr(A_ST, 32'h80);
        cst(8'h10, 8'h10);
        wr(A_ST, 32'h90);
        cst(8'hC0, 8'hF0);
        $display("test 1 done");
        dv = 8'h01 + 8'($urandom % 3);
        wr(A_DIV, {24'h0, dv});
        rd(A_DIV, r);
        chk(r, {24'h0, 1'b1, dv[6:0]}, 32'hFF);
        idx = 10'($urandom % 1000);
        for (int k = 0; k < 5; k++) begin
            d = 16'($urandom);
            mode.wait_req <= k[0];
            seq(idx, d, ops[k]);
            rd(arr(idx), r);
            chk(r, INVALID_READ, 32'hFFFF_FFFF);
            wdone();
            cst(8'hC0, 8'hF0);
            rd(arr(idx), r);
            chk(r, {16'h0, after_op(ops[k], d)}, 32'hFFFF);
            if (k == 1) cst(8'h04, 8'h04);
        end
        mode.wait_req <= 1'b0;
        // second verify waits in the pending slot, so buffers stay busy
        seq(idx, 16'h0, CMD_VERIFY);
        seq(idx, 16'h0, CMD_VERIFY);
        wr(arr(idx), 32'h0);
        cst(8'h10, 8'h90);
        wdone();
        wr(A_ST, 32'h90);
        cst(8'hC0, 8'hF0);
        $display("test 2 done");
        for (int k = 0; k < 8; k++) begin
            case (k)
                0: i_cpu.xfer(arr(idx), 1'b1, 3'h0, 32'h0, r);
                1: wr(arr(idx) + 32'h2, 32'h0);
                2: begin wr(arr(idx), 32'h0); wr(arr(idx), 32'h0); end
                3: begin wr(arr(idx), 32'h0); wr(A_CFG, 32'h0); end
                4: begin wr(arr(idx), 32'h0); wr(A_CMD, 32'h20); wr(A_CMD, 32'h20); end
                5: begin wr(arr(idx), 32'h0); wr(A_CMD, 32'h33); end
                6: begin wr(arr(idx), 32'h0); wr(A_CMD, 32'h20); wr(A_CFG, 32'h0); end
                default: begin wr(arr(idx), 32'h0); wr(A_CMD, 32'h20); wr(A_ST, 32'h0); end
            endcase
            cst(8'h10, 8'h10);
            lock_chk(8'hD0, 8'hD0);
        end
        $display("test 3 done");
        wr(A_PROT, 32'h0);
        seq(IDX_LAST, 16'h0, CMD_PROGRAM);
        cst(8'hE0, 8'hE0);
        lock_chk(8'hE0, 8'hE0);
        seq(10'h0, 16'h0, CMD_MASS_ERASE);
        cst(8'hE0, 8'hE0);
        wr(A_ST, 32'hB0);
        seq(IDX_LAST, 16'h0, CMD_SECT_ERASE);
        cst(8'hE0, 8'hE0);
        wr(A_ST, 32'hB0);
        wr(A_PROT, 32'h80);
        rd(A_PROT, r);
        chk(r, 32'h0, 32'hFF);
        mode.debug <= 1'b1;
        wr(A_PROT, 32'h80);
        rd(A_PROT, r);
        chk(r, 32'h80, 32'hFF);
        mode.secured <= 1'b1;
        mode.special <= 1'b1;
        seq(10'h0, 16'h0, CMD_PROGRAM);
        cst(8'h10, 8'h10);
        wr(A_ST, 32'hB0);
        seq(10'h0, 16'h0, CMD_MASS_ERASE);
        wdone();
        cst(8'hC0, 8'hF0);
        mode <= '0;
        $display("test 4 done");
        seq(idx, 16'h0, CMD_MASS_ERASE);
        mode.stop_req <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({31'h0, hv_on}, 32'h0, 32'h1);
        cst(8'h50, 8'h50);
        mode.stop_req <= 1'b0;
        repeat (2) @(posedge hclk);
        cst(8'hD0, 8'hD0);
        wr(A_ST, 32'hB0);
        cst(8'hC0, 8'hF0);
        wr(A_CFG, 32'hC0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        mode.irq_mask <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        mode <= 6'b100000;
        wr(A_CFG, 32'h40);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1, 32'h1);
        wr(A_CFG, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0, 32'h1);
        mode <= '0;
        $display("test 5 done");
        seq(idx, 16'h0, CMD_MASS_ERASE);
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({31'h0, hv_on}, 32'h0, 32'h1);
        hresetn <= 1'b1;
        @(posedge hclk);
        cst(8'hC0, 8'hF0);
        rd(A_DIV, r);
        chk(r, 32'h0, 32'h80);
        $display("test 6 done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
